// file: verilog/rdef_pkg.sv
// package for the receive disturbance filter: register map, fields, carriers
package rdef_pkg;
   // ==========================================================
   // register map (word index, byte address = 4 * index)
   localparam logic [7:0] RDEF_IDX_DIST_CTRL = 8'h03;
   localparam logic [7:0] RDEF_IDX_TYPEF_CTRL = 8'h04;
   localparam logic [7:0] RDEF_IDX_IRQ_STATUS = 8'h08;
   localparam logic [7:0] RDEF_IDX_IRQ_MASK = 8'h09;
   localparam logic [7:0] RDEF_IDX_LAST_RESULT = 8'h0a;
   localparam logic [31:0] RDEF_DIST_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] RDEF_TYPEF_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] RDEF_UNMAPPED_RD = 32'h0000_0000;
   // ==========================================================
   // field positions, disturbance_control
   localparam int RDEF_DC_ON = 0;
   localparam int RDEF_DC_LONG_NEVER = 1;
   localparam int RDEF_DC_THR_LO = 2;
   localparam int RDEF_DC_MISS_A = 6;
   localparam int RDEF_DC_MISS_B = 7;
   localparam int RDEF_DC_TMR_LO = 8;
   localparam int RDEF_DC_SENS_LO = 10;
   // field positions, type_f_disturbance_control
   localparam int RDEF_FC_ON = 0;
   localparam int RDEF_FC_LEN_CHK = 1;
   localparam int RDEF_FC_RC_CHK = 2;
   localparam int RDEF_FC_PROT_CHK = 3;
   localparam int RDEF_FC_INTEG_CHK = 4;
   localparam int RDEF_FC_GOOD_CRC = 5;
   localparam int RDEF_FC_LOG = 6;
   localparam int RDEF_FC_LEN_MIN_LO = 8;
   localparam int RDEF_FC_LEN_MAX_LO = 16;
   localparam int RDEF_FC_RC_LO = 24;
   // interrupt status bits
   localparam int RDEF_IRQ_REPORTED = 0;
   localparam int RDEF_IRQ_DISCARDED = 1;
   localparam int RDEF_IRQ_LOGGED = 2;
   localparam int RDEF_IRQ_W = 3;
   // ==========================================================
   // protocol families
   typedef enum logic [1:0] {
      RDEF_PROTO_A,
      RDEF_PROTO_B,
      RDEF_PROTO_F,
      RDEF_PROTO_OTHER
   } rdef_proto_e;

   // end-of-frame report from the receiver datapath
   typedef struct packed {
      logic valid;
      rdef_proto_e proto;
      logic [7:0] byte_count;
      logic crc_present;
      logic integrity_err;
      logic protocol_err;
      logic [7:0] length_byte;
      logic [7:0] request_code;
      logic [31:0] rx_status;
   } rdef_frame_s;

   // verdict for the frame
   typedef struct packed {
      logic valid;
      logic disturbance;
      logic protocol_err;
      logic integrity_err;
      logic [31:0] rx_status;
   } rdef_verdict_s;
endpackage

// file: verilog/rdef_filter.sv
// receive disturbance filter with classic wishbone register slave
// ==========================================================
`timescale 1ns/1ps
module rdef_filter #(
   parameter int CRC_BYTES_A = 2,
   parameter int CRC_BYTES_B = 2,
   parameter int CRC_BYTES_F = 2,
   parameter logic [1:0] MATCH_SENS_DEFAULT = 2'h0
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // classic wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // frame report from the receiver
   input wire rdef_pkg::rdef_frame_s FRAME_I,
   // verdict towards status logic
   output rdef_pkg::rdef_verdict_s VERDICT_O,
   output logic RX_CONTINUE_O,
   // receiver configuration
   output logic [1:0] RECEIVER_MATCHING_CONFIG_O,
   output logic [1:0] SUPERVISION_TIMER_SELECT_O,
   // interrupt
   output logic IRQ_O
);
   import rdef_pkg::*;

   // ==========================================================
   // registers
   logic [31:0] dist_ctrl_q;
   logic [31:0] typef_ctrl_q;
   logic [RDEF_IRQ_W-1:0] irq_status_q;
   logic [RDEF_IRQ_W-1:0] irq_mask_q;
   logic [31:0] last_result_q;
   logic ack_q;
   logic [31:0] rdata_q;
   rdef_verdict_s verdict_q;
   logic cont_q;
   logic [1:0] match_q;
   logic [1:0] timer_q;
   logic irq_q;

   // ==========================================================
   // bus decode; one wait state, ack for one cycle
   wire bus_req = WB_CYC_I && WB_STB_I && !ack_q;
   wire wr_en = bus_req && WB_WE_I;
   wire rd_en = bus_req && !WB_WE_I;
   wire [5:0] word_idx = WB_ADR_I[7:2];
   wire sel_dc = word_idx == RDEF_IDX_DIST_CTRL[5:0];
   wire sel_fc = word_idx == RDEF_IDX_TYPEF_CTRL[5:0];
   wire sel_st = word_idx == RDEF_IDX_IRQ_STATUS[5:0];
   wire sel_mk = word_idx == RDEF_IDX_IRQ_MASK[5:0];
   wire sel_lr = word_idx == RDEF_IDX_LAST_RESULT[5:0];
   wire [31:0] bytemask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   wire [31:0] dc_wr = (dist_ctrl_q & ~bytemask) | (WB_DAT_I & bytemask);
   wire [31:0] fc_wr = (typef_ctrl_q & ~bytemask) | (WB_DAT_I & bytemask);
   wire [31:0] mk_wr = ({29'h0, irq_mask_q} & ~bytemask) | (WB_DAT_I & bytemask);
   wire [31:0] rd_mux = sel_dc ? dist_ctrl_q :
                        sel_fc ? typef_ctrl_q :
                        sel_st ? {29'h0, irq_status_q} :
                        sel_mk ? {29'h0, irq_mask_q} :
                        sel_lr ? last_result_q : RDEF_UNMAPPED_RD;

   // ==========================================================
   // control fields
   wire dist_on = dist_ctrl_q[RDEF_DC_ON];
   wire long_never = dist_ctrl_q[RDEF_DC_LONG_NEVER];
   wire [3:0] noise_thr = dist_ctrl_q[RDEF_DC_THR_LO +: 4];
   wire miss_a = dist_ctrl_q[RDEF_DC_MISS_A];
   wire miss_b = dist_ctrl_q[RDEF_DC_MISS_B];
   wire [1:0] tmr_sel = dist_ctrl_q[RDEF_DC_TMR_LO +: 2];
   wire [1:0] sens = dist_ctrl_q[RDEF_DC_SENS_LO +: 2];
   wire f_on = typef_ctrl_q[RDEF_FC_ON];
   wire f_len_chk = typef_ctrl_q[RDEF_FC_LEN_CHK];
   wire f_rc_chk = typef_ctrl_q[RDEF_FC_RC_CHK];
   wire f_prot_chk = typef_ctrl_q[RDEF_FC_PROT_CHK];
   wire f_integ_chk = typef_ctrl_q[RDEF_FC_INTEG_CHK];
   wire f_good_crc = typef_ctrl_q[RDEF_FC_GOOD_CRC];
   wire f_log = typef_ctrl_q[RDEF_FC_LOG];
   wire [7:0] f_len_min = typef_ctrl_q[RDEF_FC_LEN_MIN_LO +: 8];
   wire [7:0] f_len_max = typef_ctrl_q[RDEF_FC_LEN_MAX_LO +: 8];
   wire [7:0] f_rc_exp = typef_ctrl_q[RDEF_FC_RC_LO +: 8];

   // ==========================================================
   // general path (every family except type f: type a / type b / other)
   wire is_a = FRAME_I.proto == RDEF_PROTO_A;
   wire is_b = FRAME_I.proto == RDEF_PROTO_B;
   wire is_f = FRAME_I.proto == RDEF_PROTO_F;
   wire [7:0] crc_len = !FRAME_I.crc_present ? 8'h00 :
                        is_a ? 8'(CRC_BYTES_A) :
                        is_b ? 8'(CRC_BYTES_B) :
                        is_f ? 8'(CRC_BYTES_F) : 8'h00;
   // count saturates at zero so a short frame cannot wrap into a long one
   wire [7:0] payload_len = (FRAME_I.byte_count > crc_len) ?
                            8'(FRAME_I.byte_count - crc_len) : 8'h00;
   wire missing_crc_err = !FRAME_I.crc_present &&
                          ((is_a && miss_a) || (is_b && miss_b));
   wire prot_err = FRAME_I.protocol_err || missing_crc_err;
   wire has_err = prot_err || FRAME_I.integrity_err;
   wire below_thr = payload_len < {4'h0, noise_thr};
   // an erroneous frame below threshold is noise; the long bit only forbids the long case explicitly
   wire gen_noise = dist_on && !is_f && has_err && below_thr &&
                    !(long_never && !below_thr);

   // ==========================================================
   // type f path
   wire f_len_bad = f_len_chk &&
                    (FRAME_I.length_byte < f_len_min ||
                     FRAME_I.length_byte > f_len_max);
   wire f_rc_bad = f_rc_chk && (FRAME_I.request_code != f_rc_exp);
   wire f_by_prot = f_prot_chk && prot_err;
   wire f_by_integ = f_integ_chk && FRAME_I.integrity_err;
   wire f_clean = !FRAME_I.integrity_err && FRAME_I.crc_present;
   wire f_good_rc = f_good_crc && f_clean && f_rc_bad;
   wire f_noise = f_on && is_f &&
                  (((f_by_prot || f_by_integ) && (f_len_bad || f_rc_bad)) ||
                   f_good_rc);
   wire is_noise = gen_noise || f_noise;

   // ==========================================================
   // verdict: disturbance frames are swallowed except type f ones with logging on, reception keeps going
   wire fv = FRAME_I.valid;
   wire report = fv && !is_noise;
   wire logged = fv && f_noise && f_log;
   rdef_verdict_s verdict_d;
   assign verdict_d.valid = report || logged;
   assign verdict_d.disturbance = fv && is_noise;
   assign verdict_d.protocol_err = fv && prot_err;
   assign verdict_d.integrity_err = fv && FRAME_I.integrity_err;
   assign verdict_d.rx_status = (report || logged) ? FRAME_I.rx_status : 32'h0000_0000;
   wire cont_d = fv && is_noise;
   wire [RDEF_IRQ_W-1:0] irq_evt = {logged, fv && is_noise, report};
   wire [RDEF_IRQ_W-1:0] st_clr = (rd_en && sel_st) ? {RDEF_IRQ_W{1'b1}} : '0;
   // set wins over the read clear
   wire [RDEF_IRQ_W-1:0] st_d = (irq_status_q & ~st_clr) | irq_evt;
   wire [31:0] lr_d = fv ? {27'h0, prot_err, FRAME_I.integrity_err, f_noise,
                            gen_noise, report} : last_result_q;
   wire [1:0] match_d = dist_on ? sens : MATCH_SENS_DEFAULT;
   wire [1:0] timer_d = tmr_sel;
   wire irq_d = |(st_d & irq_mask_q);

   // ==========================================================
   // flip-flops
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         dist_ctrl_q <= RDEF_DIST_CTRL_RST;
         typef_ctrl_q <= RDEF_TYPEF_CTRL_RST;
         irq_mask_q <= '0;
      end else if (wr_en) begin
         if (sel_dc) dist_ctrl_q <= dc_wr;
         if (sel_fc) typef_ctrl_q <= fc_wr;
         if (sel_mk) irq_mask_q <= mk_wr[RDEF_IRQ_W-1:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         irq_status_q <= '0;
         last_result_q <= 32'h0000_0000;
      end else begin
         ack_q <= bus_req;
         rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
         irq_status_q <= st_d;
         last_result_q <= lr_d;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         verdict_q <= '0;
         cont_q <= 1'b0;
         match_q <= MATCH_SENS_DEFAULT;
         timer_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         verdict_q <= verdict_d;
         cont_q <= cont_d;
         match_q <= match_d;
         timer_q <= timer_d;
         irq_q <= irq_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdata_q;
   assign VERDICT_O = verdict_q;
   assign RX_CONTINUE_O = cont_q;
   assign RECEIVER_MATCHING_CONFIG_O = match_q;
   assign SUPERVISION_TIMER_SELECT_O = timer_q;
   assign IRQ_O = irq_q;
endmodule // rdef_filter

// file: sim/rdef_card_model.sv
// far-side model: frame reports as the receiver hands them over
`timescale 1ns/1ps
module rdef_card_model
   import rdef_pkg::*;
(
   // clock
   input wire logic clk,
   // request from the bench
   input wire logic go,
   input wire rdef_pkg::rdef_frame_s frm,
   // frame report towards the filter
   output rdef_pkg::rdef_frame_s frame_o
);
   // ==========================================================
   // one-cycle report
   initial frame_o = '0;
   // stale fields are inverted so the filter cannot lean on leftovers
   always @(posedge clk) begin
      if (go) begin
         frame_o <= frm;
      end else begin
         frame_o <= {1'b0, ~frame_o[$bits(rdef_frame_s)-2:0]};
      end
   end
endmodule // rdef_card_model

// file: sim/rdef_filter_props.sv
// port-level assertions for the receive disturbance filter
`timescale 1ns/1ps
module rdef_filter_props
   import rdef_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // register bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // frame path
   input wire rdef_pkg::rdef_frame_s FRAME_I,
   input wire rdef_pkg::rdef_verdict_s VERDICT_O,
   input wire logic RX_CONTINUE_O,
   input wire logic [1:0] SUPERVISION_TIMER_SELECT_O,
   input wire logic IRQ_O
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // ==========================================================
   // register bus
   a_ack_one_wait: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("bus request not answered after one cycle");
   a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_read_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
      else $error("read data outside ack");
   a_timer_by_write: assert property (!$stable(SUPERVISION_TIMER_SELECT_O) |->
      $past(WB_WE_I) || $past(WB_WE_I, 2)) else $error("timer select moved without write");
   // ==========================================================
   // frame path
   a_frame_answered: assert property (FRAME_I.valid |=> VERDICT_O.valid || RX_CONTINUE_O)
      else $error("frame got no verdict");
   a_no_stray_verdict: assert property (!FRAME_I.valid |=>
      !VERDICT_O.valid && !RX_CONTINUE_O) else $error("verdict without frame");
   a_discard_marked: assert property (RX_CONTINUE_O |-> VERDICT_O.disturbance)
      else $error("discard without disturbance flag");
   a_clean_ab_kept: assert property (FRAME_I.valid && FRAME_I.crc_present &&
      !FRAME_I.integrity_err && !FRAME_I.protocol_err && FRAME_I.proto inside
      {RDEF_PROTO_A, RDEF_PROTO_B} |=> VERDICT_O.valid && !VERDICT_O.disturbance)
      else $error("clean frame not reported");
   a_status_forward: assert property (FRAME_I.valid ##1 VERDICT_O.valid |->
      VERDICT_O.rx_status == $past(FRAME_I.rx_status)) else $error("rx status altered");
   a_irq_cause: assert property ($rose(IRQ_O) |-> $past(FRAME_I.valid) ||
      $past(WB_WE_I) || $past(WB_WE_I, 2)) else $error("interrupt without cause");
   c_discard: cover property (RX_CONTINUE_O);
   c_logged: cover property (VERDICT_O.valid && VERDICT_O.disturbance);
   c_irq: cover property ($rose(IRQ_O));
endmodule // rdef_filter_props
bind rdef_filter rdef_filter_props i_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .FRAME_I(FRAME_I), .VERDICT_O(VERDICT_O),
   .RX_CONTINUE_O(RX_CONTINUE_O), .SUPERVISION_TIMER_SELECT_O(SUPERVISION_TIMER_SELECT_O),
   .IRQ_O(IRQ_O));

// file: sim/rdef_filter_tb.sv
// self-checking bench for the receive disturbance filter
`timescale 1ns/1ps
module rdef_filter_tb;
   import rdef_pkg::*;
   localparam rdef_proto_e PA = RDEF_PROTO_A;
   localparam rdef_proto_e PB = RDEF_PROTO_B;
   localparam rdef_proto_e PF = RDEF_PROTO_F;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] q;
   rdef_frame_s frm = '0;
   rdef_frame_s frame_w;
   rdef_verdict_s verdict_w;
   logic [31:0] rdat_w;
   logic ack_w;
   logic cont_w;
   logic irq_w;
   logic [1:0] match_w;
   logic [1:0] tmr_w;
   int err_total = 0;
   int cmp_count = 0;
   int cyc_n = 0;
   always #25 SYS_CLK = ~SYS_CLK;
   rdef_card_model i_card (.clk(SYS_CLK), .go(go), .frm(frm), .frame_o(frame_w));
   rdef_filter i_dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat_w),
      .WB_ACK_O(ack_w), .FRAME_I(frame_w), .VERDICT_O(verdict_w), .RX_CONTINUE_O(cont_w),
      .RECEIVER_MATCHING_CONFIG_O(match_w), .SUPERVISION_TIMER_SELECT_O(tmr_w), .IRQ_O(irq_w));
   // ==========================================================
   // report and checks
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   always @(posedge SYS_CLK) begin
      cyc_n++;
      if (cyc_n == 4000) begin
         err_total++;
         wrap_up();
      end
   end
   // ==========================================================
   // bus and frame access
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // no cycle budget here: only the bench timeout ends a stalled wait
      do begin
         @(posedge SYS_CLK);
      end while (ack_w !== 1'b1);
      q = rdat_w;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask
   // exp is {verdict valid (reported or logged), disturbance, protocol error while valid}
   task automatic fs(input rdef_proto_e p, input logic [7:0] bc, input logic [2:0] fl,
      input logic [2:0] exp, input logic [7:0] ln = 8'h00, input logic [7:0] rc = 8'ha5);
      frm <= '{1'b1, p, bc, fl[2], fl[1], fl[0], ln, rc, 32'h0000_5a3c};
      go <= 1'b1;
      @(posedge SYS_CLK);
      go <= 1'b0;
      @(posedge SYS_CLK);
      #1;
      chk({29'h0, verdict_w.valid, verdict_w.disturbance,
         verdict_w.valid & verdict_w.protocol_err}, {29'h0, exp});
      chk({31'h0, cont_w}, {31'h0, exp[1]});
      chk({31'h0, verdict_w.integrity_err}, {31'h0, fl[1]});
      chk(verdict_w.rx_status, exp[2] ? 32'h0000_5a3c : 32'h0000_0000);
      @(posedge SYS_CLK);
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (16) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      @(posedge SYS_CLK);
      rdc(8'h0c, 32'h0000_0000);
      rdc(8'h10, 32'h0000_0000);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      rdc(8'h3c, 32'h0000_0000);
      wb(1'b1, 8'h0c, 32'h0000_0911);
      rdc(8'h0c, 32'h0000_0911);
      chk({30'h0, match_w}, 32'h2);
      chk({30'h0, tmr_w}, 32'h1);
      fs(PA, 8'h05, 3'h6, 3'h2);
      fs(PA, 8'h06, 3'h6, 3'h4);
      fs(PB, 8'h03, 3'h2, 3'h2);
      fs(PA, 8'h05, 3'h4, 3'h4);
      wb(1'b1, 8'h0c, 32'h0000_0913);
      fs(PA, 8'h06, 3'h6, 3'h4);
      fs(PA, 8'h05, 3'h6, 3'h2);
      wb(1'b1, 8'h0c, 32'h0000_0910);
      fs(PA, 8'h05, 3'h6, 3'h4);
      chk({30'h0, match_w}, 32'h0);
      chk({30'h0, tmr_w}, 32'h1);
      $display("test general path done");
      wb(1'b1, 8'h0c, 32'h0000_00c1);
      fs(PA, 8'h04, 3'h0, 3'h5);
      fs(PB, 8'h04, 3'h0, 3'h5);
      wb(1'b1, 8'h0c, 32'h0000_0001);
      fs(PA, 8'h04, 3'h0, 3'h4);
      fs(PB, 8'h04, 3'h0, 3'h4);
      $display("test missing crc done");
      wb(1'b1, 8'h10, 32'ha520_100b);
      fs(PF, 8'h08, 3'h5, 3'h5, 8'h20);
      fs(PF, 8'h08, 3'h5, 3'h2, 8'h21);
      fs(PF, 8'h08, 3'h5, 3'h2, 8'h0f);
      fs(PF, 8'h08, 3'h5, 3'h5, 8'h10);
      fs(PF, 8'h08, 3'h6, 3'h4, 8'h21);
      wb(1'b1, 8'h10, 32'ha520_101b);
      fs(PF, 8'h08, 3'h6, 3'h2, 8'h21);
      wb(1'b1, 8'h10, 32'ha520_1013);
      fs(PF, 8'h08, 3'h5, 3'h5, 8'h21);
      wb(1'b1, 8'h10, 32'ha520_100d);
      fs(PF, 8'h08, 3'h5, 3'h2, 8'h21, 8'ha4);
      fs(PF, 8'h08, 3'h5, 3'h5, 8'h21);
      wb(1'b1, 8'h10, 32'ha520_100c);
      fs(PF, 8'h08, 3'h5, 3'h5, 8'h21, 8'ha4);
      wb(1'b1, 8'h10, 32'ha520_1065);
      rdc(8'h10, 32'ha520_1065);
      fs(PF, 8'h08, 3'h4, 3'h6, 8'h21, 8'ha4);
      wb(1'b1, 8'h10, 32'ha520_1025);
      fs(PF, 8'h08, 3'h4, 3'h2, 8'h21, 8'ha4);
      fs(PF, 8'h08, 3'h4, 3'h4, 8'h21);
      $display("test type f path done");
      wb(1'b0, 8'h20, 32'h0000_0000);
      wb(1'b1, 8'h24, 32'h0000_0002);
      fs(PF, 8'h08, 3'h4, 3'h2, 8'h21, 8'ha4);
      chk({31'h0, irq_w}, 32'h1);
      rdc(8'h20, 32'h0000_0002);
      chk({31'h0, irq_w}, 32'h0);
      wb(1'b1, 8'h24, 32'h0000_0000);
      fs(PF, 8'h08, 3'h4, 3'h2, 8'h21, 8'ha4);
      chk({31'h0, irq_w}, 32'h0);
      rdc(8'h28, 32'h0000_0004);
      $display("test interrupt done");
      wrap_up();
   end
endmodule // rdef_filter_tb
